// file: rtl/tnu_pkg.sv
package tnu_pkg;
  // Cause codes
  localparam logic [10:0] CODE_IACC    = 11'h001;
  localparam logic [10:0] CODE_ILL     = 11'h002;
  localparam logic [10:0] CODE_BRK     = 11'h003;
  localparam logic [10:0] CODE_LACC    = 11'h005;
  localparam logic [10:0] CODE_SACC    = 11'h007;
  localparam logic [10:0] CODE_UCALL   = 11'h008;
  localparam logic [10:0] CODE_MCALL   = 11'h00B;
  localparam logic [10:0] CODE_IBUS    = 11'h018;
  localparam logic [10:0] CODE_IINTEG  = 11'h019;
  localparam logic [10:0] CODE_NMI_LB  = 11'h400;
  localparam logic [10:0] CODE_NMI_SB  = 11'h401;
  localparam logic [10:0] CODE_NMI_LI  = 11'h402;
  localparam logic [10:0] CODE_NMI_SI  = 11'h403;
  localparam int          CAUSE_IRQ_BIT = 31;
  // Vector layout
  localparam int          VEC_BASE_LSB = 7;
  localparam logic [4:0]  VEC_IDX_ZERO = 5'h00;
  localparam logic [4:0]  VEC_IDX_NMI  = 5'h0F;
  localparam logic [1:0]  VEC_WORD_OFS = 2'h0;
  localparam logic [6:0]  VEC_EXC_LOW  = 7'h00;
  // Scheme select values
  localparam bit          SCHEME_BASIC = 1'b0;
  localparam bit          SCHEME_LEVEL = 1'b1;
  // Retirement allowance once an NMI is visible
  localparam logic [1:0]  NMI_RETIRE_MAX = 2'h2;
  // Register offsets
  localparam logic [7:0]  OFS_TVEC   = 8'h00;
  localparam logic [7:0]  OFS_STATUS = 8'h04;
  localparam logic [7:0]  OFS_EPC    = 8'h08;
  localparam logic [7:0]  OFS_CAUSE  = 8'h0C;
  localparam logic [7:0]  OFS_DBGCTL = 8'h10;
  // Field positions
  localparam int          TVEC_MODE_BIT   = 0;
  localparam int          STAT_MIE_BIT    = 3;
  localparam int          STAT_MPIE_BIT   = 7;
  localparam int          DBG_STEP_IRQ_ENABLE_BIT  = 2;
  localparam int          DBG_NMIP_BIT    = 3;
  // Reset values
  localparam logic [31:0] TVEC_RST   = 32'h0000_0000;
  localparam logic [31:0] ZERO_WORD  = 32'h0000_0000;
  // Bus encodings
  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0]  HTRANS_SEQ    = 2'h3;
  localparam logic        HRESP_OKAY    = 1'b0;
endpackage

// file: rtl/tnu_trap_unit.sv
// Operation
// - Build parameter picks basic or level scheme
// - Fetch from I/O or protection fail: code 1
// - Bad load access gives code 5
// - Bad store or atomic gives code 7
// - Fetch bus error executed gives code 24
// - Fetch integrity error gives code 25
// - Calls give 8 or 11, breakpoint 3
// - Only highest priority exception is reported
// - Undefined encodings illegal unless custom-enabled
// - Exceptions never masked, always precise
// - Fetch faults count only when executed
// - NMI updates return address, cause, status
// - NMI entry clears global interrupt enable
// - NMI outranks every other interrupt
// - NMI vector index 0 or 15
// - Data bus fault instruction retires, NMI after
// - NMI masked in debug or unstepped step
// - At most two retirements once NMI visible
// - NMI pending in debug taken on exit
// - Bufferable store fault may surface late
// - First data fault latched until handler entry
// - Debug pending flag mirrors NMI pending in debug mode, reads 0 outside
// - NMI causes 1024 to 1027 with irq set
module tnu_trap_unit
  import tnu_pkg::*;
#(
  parameter bit IRQ_SCHEME_SELECT = SCHEME_BASIC
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  input  wire logic        ex_valid,
  input  wire logic [31:0] ex_pc,
  input  wire logic        ex_fetch_io,
  input  wire logic        ex_fetch_prot_fail,
  input  wire logic        ex_fetch_bus_err,
  input  wire logic        ex_fetch_integ_err,
  input  wire logic        ex_illegal_enc,
  input  wire logic        ex_custom_enabled,
  input  wire logic        ex_system_call,
  input  wire logic        ex_user_priv,
  input  wire logic        ex_breakpoint,
  input  wire logic        ex_load_fault,
  input  wire logic        ex_store_fault,
  input  wire logic        data_rvalid,
  input  wire logic        data_err,
  input  wire logic        data_integ_err,
  input  wire logic        data_is_store,
  input  wire logic        debug_mode,
  input  wire logic        single_step,
  output logic             ex_retire,
  output logic             trap_take,
  output logic             flush,
  output logic [31:0]      trap_target_q,
  output logic [31:0]      cause_q,
  output logic [31:0]      epc_q,
  output logic             nmi_pending
);

  logic        exc;
  logic [10:0] exc_code;
  logic        nmi_pend_q;
  logic [10:0] nmi_code_q;
  logic        nmi_visible;
  logic        nmi_take;
  logic [1:0]  ret_cnt_q;
  logic [31:0] tvec_q;
  logic        mie_q;
  logic        mpie_q;
  logic        step_irq_enable_q;
  logic        fault_in;
  logic [10:0] fault_code;
  logic [4:0]  nmi_idx;
  logic        aphase;
  logic        wr_q;
  logic [7:0]  wofs_q;
  logic [31:0] rd_d;

  // Priority encoder over the exceptions of the executing instruction
  always_comb begin
    exc      = ex_valid;
    exc_code = CODE_IACC;
    if (ex_fetch_io || ex_fetch_prot_fail) begin
      exc_code = CODE_IACC;
    end else if (ex_fetch_integ_err) begin
      exc_code = CODE_IINTEG;
    end else if (ex_fetch_bus_err) begin
      exc_code = CODE_IBUS;
    end else if (ex_illegal_enc && !ex_custom_enabled) begin
      exc_code = CODE_ILL;
    end else if (ex_system_call) begin
      exc_code = ex_user_priv ? CODE_UCALL : CODE_MCALL;
    end else if (ex_breakpoint) begin
      exc_code = CODE_BRK;
    end else if (ex_store_fault) begin
      exc_code = CODE_SACC;
    end else if (ex_load_fault) begin
      exc_code = CODE_LACC;
    end else begin
      exc = 1'b0;
    end
  end

  // NMI masking and the retirement allowance
  assign nmi_visible = nmi_pend_q && !debug_mode && !(single_step && !step_irq_enable_q);
  assign nmi_take    = nmi_visible && !exc;
  assign trap_take   = exc || nmi_take;
  assign flush       = trap_take;
  assign ex_retire   = ex_valid && !exc && !nmi_take &&
                       !(nmi_visible && ret_cnt_q == NMI_RETIRE_MAX);
  assign nmi_pending = nmi_pend_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ret_cnt_q <= 2'h0;
    end else if (!nmi_visible) begin
      ret_cnt_q <= 2'h0;
    end else if (ex_retire) begin
      ret_cnt_q <= ret_cnt_q + 2'h1;
    end
  end

  // Data bus fault capture; the first fault wins until handler entry
  assign fault_in   = data_rvalid && (data_err || data_integ_err);
  assign fault_code = data_integ_err ? (data_is_store ? CODE_NMI_SI : CODE_NMI_LI)
                                     : (data_is_store ? CODE_NMI_SB : CODE_NMI_LB);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      nmi_pend_q <= 1'b0;
      nmi_code_q <= CODE_NMI_LB;
    end else if (fault_in && (!nmi_pend_q || nmi_take)) begin
      nmi_pend_q <= 1'b1;
      nmi_code_q <= fault_code;
    end else if (nmi_take) begin
      nmi_pend_q <= 1'b0;
    end
  end

  assign nmi_idx = (IRQ_SCHEME_SELECT == SCHEME_BASIC && tvec_q[TVEC_MODE_BIT])
                   ? VEC_IDX_NMI : VEC_IDX_ZERO;

  // Trap state saved on entry
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      epc_q         <= ZERO_WORD;
      cause_q       <= ZERO_WORD;
      trap_target_q <= ZERO_WORD;
    end else if (exc) begin
      epc_q         <= ex_pc;
      cause_q       <= {21'h0, exc_code};
      trap_target_q <= {tvec_q[31:VEC_BASE_LSB], VEC_EXC_LOW};
    end else if (nmi_take) begin
      epc_q         <= ex_pc;
      cause_q       <= {1'b1, 20'h0, nmi_code_q};
      trap_target_q <= {tvec_q[31:VEC_BASE_LSB], nmi_idx, VEC_WORD_OFS};
    end
  end

  // Status: trap entry saves and clears the global enable, beating a bus write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mie_q  <= 1'b0;
      mpie_q <= 1'b0;
    end else if (trap_take) begin
      mie_q  <= 1'b0;
      mpie_q <= mie_q;
    end else if (wr_q && wofs_q == OFS_STATUS) begin
      mie_q  <= hwdata[STAT_MIE_BIT];
      mpie_q <= hwdata[STAT_MPIE_BIT];
    end
  end

  // Vector base: the low bits other than the mode bit read as zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tvec_q <= TVEC_RST;
    end else if (wr_q && wofs_q == OFS_TVEC) begin
      tvec_q <= {hwdata[31:VEC_BASE_LSB], 6'h0, hwdata[TVEC_MODE_BIT]};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      step_irq_enable_q <= 1'b0;
    end else if (wr_q && wofs_q == OFS_DBGCTL) begin
      step_irq_enable_q <= hwdata[DBG_STEP_IRQ_ENABLE_BIT];
    end
  end

  // Bus slave: zero wait states, always OKAY
  assign aphase    = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
  assign hreadyout = 1'b1;
  assign hresp     = HRESP_OKAY;

  always_comb begin
    rd_d = ZERO_WORD;
    unique case (haddr[7:0])
      OFS_TVEC:   rd_d = tvec_q;
      OFS_STATUS: rd_d = {24'h0, mpie_q, 3'h0, mie_q, 3'h0};
      OFS_EPC:    rd_d = epc_q;
      OFS_CAUSE:  rd_d = cause_q;
      OFS_DBGCTL: rd_d = {28'h0, nmi_pend_q && debug_mode, step_irq_enable_q, 2'h0};
      default:    rd_d = ZERO_WORD;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q   <= 1'b0;
      wofs_q <= 8'h00;
      hrdata <= ZERO_WORD;
    end else begin
      wr_q   <= aphase && hwrite;
      wofs_q <= haddr[7:0];
      if (aphase && !hwrite) begin
        hrdata <= rd_d;
      end
    end
  end

  // Helper terms for the priority checks
  logic chk_fetch;
  logic chk_ill;
  logic chk_call;
  assign chk_fetch = ex_fetch_io || ex_fetch_prot_fail || ex_fetch_integ_err || ex_fetch_bus_err;
  assign chk_ill   = ex_illegal_enc && !ex_custom_enabled;
  assign chk_call  = ex_system_call || ex_breakpoint;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_nmi_retire_cap: assert property (nmi_visible |-> ret_cnt_q <= NMI_RETIRE_MAX)
    else $error("more than two retirements with NMI visible");

  a_exc_no_retire: assert property (exc |-> !ex_retire && flush)
    else $error("excepting instruction retired");

  a_exc_cause: assert property (exc |=> !cause_q[CAUSE_IRQ_BIT] && epc_q == $past(ex_pc))
    else $error("exception cause or return address wrong");

  a_nmi_cause: assert property (nmi_take |=> cause_q[CAUSE_IRQ_BIT] && !mie_q)
    else $error("NMI entry did not set irq bit or clear enable");

  a_nmi_masked: assert property (debug_mode |-> !nmi_take)
    else $error("NMI taken in debug mode");

  a_nmi_latch: assert property (nmi_pend_q && !nmi_take |=> $stable(nmi_code_q))
    else $error("pending NMI cause overwritten");

  a_nmi_set: assert property (fault_in && !nmi_pend_q |=> nmi_pend_q)
    else $error("data bus fault not latched");

  a_debug_exit: assert property ($fell(debug_mode) && nmi_pend_q && !single_step && !exc
                                 |-> nmi_take)
    else $error("pending NMI not taken on debug exit");

  a_prio_iacc: assert property (ex_valid && ex_fetch_io |=> cause_q == {21'h0, CODE_IACC})
    else $error("access fault not top priority");

  a_nmi_vector: assert property (nmi_take |=> trap_target_q[6:0] == {$past(nmi_idx), VEC_WORD_OFS})
    else $error("NMI vector index wrong");

  a_scheme_level: assert property (IRQ_SCHEME_SELECT != SCHEME_BASIC |-> nmi_idx == VEC_IDX_ZERO)
    else $error("level scheme NMI index not zero");

  a_vec_index15: assert property (IRQ_SCHEME_SELECT == SCHEME_BASIC && tvec_q[TVEC_MODE_BIT]
                                  |-> nmi_idx == VEC_IDX_NMI)
    else $error("vectored basic NMI index not fifteen");

  a_direct_index0: assert property (!tvec_q[TVEC_MODE_BIT] |-> nmi_idx == VEC_IDX_ZERO)
    else $error("direct mode NMI index not zero");

  a_iacc_io: assert property (ex_valid && ex_fetch_io |-> exc && exc_code == CODE_IACC)
    else $error("I/O fetch did not give access fault");

  a_iacc_prot: assert property (ex_valid && ex_fetch_prot_fail |-> exc && exc_code == CODE_IACC)
    else $error("protection fetch fail did not give access fault");

  a_integ_code: assert property (ex_valid && ex_fetch_integ_err && !ex_fetch_io && !ex_fetch_prot_fail
                                 |-> exc && exc_code == CODE_IINTEG)
    else $error("fetch integrity fault code wrong");

  a_ibus_code: assert property (ex_valid && ex_fetch_bus_err && !ex_fetch_io && !ex_fetch_prot_fail
                                && !ex_fetch_integ_err |-> exc && exc_code == CODE_IBUS)
    else $error("fetch bus fault code wrong");

  a_exec_only: assert property (!ex_valid |-> !exc)
    else $error("exception raised without execution attempt");

  a_ill_code: assert property (ex_valid && chk_ill && !chk_fetch |-> exc && exc_code == CODE_ILL)
    else $error("illegal encoding code wrong");

  a_ucall_code: assert property (ex_valid && ex_system_call && ex_user_priv && !chk_fetch && !chk_ill
                                 |-> exc_code == CODE_UCALL)
    else $error("user call code wrong");

  a_mcall_code: assert property (ex_valid && ex_system_call && !ex_user_priv && !chk_fetch && !chk_ill
                                 |-> exc_code == CODE_MCALL)
    else $error("machine call code wrong");

  a_brk_code: assert property (ex_valid && ex_breakpoint && !ex_system_call && !chk_fetch && !chk_ill
                               |-> exc_code == CODE_BRK)
    else $error("breakpoint code wrong");

  a_store_code: assert property (ex_valid && ex_store_fault && !chk_fetch && !chk_ill && !chk_call
                                 |-> exc && exc_code == CODE_SACC)
    else $error("store access fault code wrong");

  a_load_code: assert property (ex_valid && ex_load_fault && !ex_store_fault && !chk_fetch && !chk_ill
                                && !chk_call |-> exc && exc_code == CODE_LACC)
    else $error("load access fault code wrong");

  a_exc_unmasked: assert property (ex_valid && (chk_fetch || chk_ill || chk_call || ex_store_fault
                                   || ex_load_fault) |-> trap_take)
    else $error("exception was masked");

  a_exc_vector: assert property (exc |=> trap_target_q[VEC_BASE_LSB-1:0] == VEC_EXC_LOW)
    else $error("exception target low bits not zero");

  a_nmi_flush: assert property (nmi_take |-> flush && !ex_retire)
    else $error("NMI entry did not flush");

  a_nmi_epc: assert property (nmi_take |=> epc_q == $past(ex_pc))
    else $error("NMI return address not saved");

  a_trap_mpie: assert property (trap_take |=> mpie_q == $past(mie_q))
    else $error("previous enable not saved on trap");

  a_nmi_prio: assert property (nmi_visible && !exc |-> nmi_take)
    else $error("visible NMI not taken");

  a_mie_ignored: assert property (nmi_pend_q && !mie_q && !debug_mode && !single_step && !exc
                                  |-> nmi_take)
    else $error("NMI masked by global enable");

  a_step_mask: assert property (single_step && !step_irq_enable_q |-> !nmi_take)
    else $error("NMI taken while stepping with step enable clear");

  a_step_open: assert property (single_step && step_irq_enable_q && nmi_pend_q && !debug_mode && !exc
                                |-> nmi_take)
    else $error("NMI not taken while stepping with step enable set");

  a_retire_block: assert property (nmi_visible && ret_cnt_q == NMI_RETIRE_MAX |-> !ex_retire)
    else $error("retirement past the NMI allowance");

  a_late_store: assert property (fault_in && data_is_store && (!nmi_pend_q || nmi_take)
                                 |=> nmi_code_q[0])
    else $error("store fault not recorded as store");

  a_latch_code: assert property (fault_in && !nmi_pend_q |=> nmi_code_q == $past(fault_code))
    else $error("first data fault cause not latched");

  a_pend_hold: assert property (nmi_pend_q && !nmi_take |=> nmi_pend_q)
    else $error("pending NMI dropped before entry");

  a_rearm: assert property (nmi_take && fault_in |=> nmi_pend_q && nmi_code_q == $past(fault_code))
    else $error("fault at handler entry not latched");

  a_pend_clear: assert property (nmi_take && !fault_in |=> !nmi_pend_q)
    else $error("pending NMI not cleared on entry");

  a_dbg_flag: assert property (debug_mode && nmi_pend_q && aphase && !hwrite
                               && haddr[7:0] == OFS_DBGCTL |=> hrdata[DBG_NMIP_BIT])
    else $error("debug pending flag not shown");

  a_dbg_hidden: assert property (!debug_mode && aphase && !hwrite && haddr[7:0] == OFS_DBGCTL
                                 |=> !hrdata[DBG_NMIP_BIT])
    else $error("debug pending flag visible outside debug");

  a_nmi_code: assert property (nmi_take |=> cause_q[10:0] == $past(nmi_code_q))
    else $error("NMI cause code wrong");

  a_nmi_base: assert property (nmi_take |=> trap_target_q[31:VEC_BASE_LSB]
                               == $past(tvec_q[31:VEC_BASE_LSB]))
    else $error("NMI target base wrong");

  c_exc_taken:  cover property (exc);
  c_nmi_taken:  cover property (nmi_take);
  c_nmi_capped: cover property (nmi_visible && ret_cnt_q == NMI_RETIRE_MAX && ex_valid);
  c_dbg_exit:   cover property ($fell(debug_mode) && nmi_pend_q);
  c_nmi_vect:   cover property (nmi_take && nmi_idx == VEC_IDX_NMI);

endmodule

// file: tb/tnu_pipe_model.sv
module tnu_pipe_model (
  input  wire logic hclk,
  input  wire logic fire,
  input  wire logic is_store,
  input  wire logic integ,
  output logic      data_rvalid,
  output logic      data_err,
  output logic      data_integ_err,
  output logic      data_is_store
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    data_rvalid = 1'b0;
    data_err = 1'b0;
    data_integ_err = 1'b0;
    data_is_store = 1'b0;
  end
  // Flags wander while no response stands, so only rvalid may qualify them
  always @(posedge hclk) begin
    data_rvalid <= fire;
    data_err <= fire ? !integ : ~data_err;
    data_integ_err <= fire ? integ : ~data_integ_err;
    data_is_store <= fire ? is_store : ~data_is_store;
  end
endmodule

// file: tb/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import tnu_pkg::*;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, ex_valid = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, ex_pc = 32'h0000_1000, r;
  logic [31:0] cause_q, epc_q, trap_target_q;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2;
  logic [10:0] exf = 0;
  logic hreadyout, hresp, ex_retire, trap_take, flush, nmi_pending;
  logic fire = 0, st = 0, ig = 0, dv, de, di, ds, debug_mode = 0, single_step = 0;
  int mismatches = 0, checks_done = 0, cyc = 0;
  logic [10:0] ef [20] = '{11'h001, 11'h002, 11'h004, 11'h008, 11'h010, 11'h030, 11'h0C0,
    11'h040, 11'h100, 11'h200, 11'h400, 11'h000, 11'h7DF, 11'h7DC, 11'h7D4, 11'h7D0,
    11'h7C0, 11'h740, 11'h700, 11'h600};
  logic [10:0] ec [20] = '{CODE_IACC, CODE_IACC, CODE_IBUS, CODE_IINTEG, CODE_ILL, 11'h7FF,
    CODE_UCALL, CODE_MCALL, CODE_BRK, CODE_SACC, CODE_LACC, 11'h7FF, CODE_IACC, CODE_IINTEG,
    CODE_IBUS, CODE_ILL, CODE_UCALL, CODE_MCALL, CODE_BRK, CODE_SACC};
  initial forever #12.5 hclk = ~hclk;
  tnu_trap_unit #(.IRQ_SCHEME_SELECT(SCHEME_BASIC)) uut (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .ex_valid(ex_valid), .ex_pc(ex_pc), .ex_fetch_io(exf[0]),
    .ex_fetch_prot_fail(exf[1]), .ex_fetch_bus_err(exf[2]), .ex_fetch_integ_err(exf[3]),
    .ex_illegal_enc(exf[4]), .ex_custom_enabled(exf[5]), .ex_system_call(exf[6]),
    .ex_user_priv(exf[7]), .ex_breakpoint(exf[8]), .ex_store_fault(exf[9]),
    .ex_load_fault(exf[10]), .data_rvalid(dv), .data_err(de), .data_integ_err(di),
    .data_is_store(ds), .debug_mode(debug_mode), .single_step(single_step),
    .ex_retire(ex_retire), .trap_take(trap_take), .flush(flush),
    .trap_target_q(trap_target_q), .cause_q(cause_q), .epc_q(epc_q),
    .nmi_pending(nmi_pending));
  tnu_pipe_model pm (.hclk(hclk), .fire(fire), .is_store(st), .integ(ig),
    .data_rvalid(dv), .data_err(de), .data_integ_err(di), .data_is_store(ds));
  task test_done();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1; haddr <= {24'h0, a}; htrans <= HTRANS_NONSEQ; hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    q = hrdata;
  endtask
  task exc(input logic [10:0] f, input logic [10:0] c);
    logic tk;
    tk = (c !== 11'h7FF);
    exf <= f; ex_valid <= 1'b1; ex_pc <= ex_pc + 32'h4;
    #1;
    chk(trap_take, tk);
    chk(flush, tk);
    chk(ex_retire, !tk);
    @(posedge hclk);
    exf <= 11'h000; ex_valid <= 1'b0;
    #1;
    if (tk) begin
      chk(cause_q, {21'h0, c});
      chk(epc_q, ex_pc);
      chk(trap_target_q, 32'h0000_4000);
    end
  endtask
  task fault(input logic s, input logic g);
    @(posedge hclk);
    fire <= 1'b1; st <= s; ig <= g;
    @(posedge hclk);
    fire <= 1'b0;
  endtask
  task wait_trap(input logic [31:0] c, input logic [31:0] t);
    int n;
    n = 0;
    #1;
    while (trap_take !== 1'b1 && n < 10) begin
      @(posedge hclk);
      #1;
      n++;
    end
    chk(n < 10, 1);
    @(posedge hclk);
    #1;
    chk(cause_q, c);
    chk(trap_target_q, t);
  endtask
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 3000) begin
      mismatches++;
      test_done();
    end
  end
  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    bus(0, OFS_TVEC, 0, r);
    chk(r, TVEC_RST);
    bus(1, OFS_TVEC, 32'h0000_4001, r);
    bus(0, OFS_TVEC, 0, r);
    chk(r, 32'h0000_4001);
    bus(1, OFS_EPC, 32'hFFFF_FFFF, r);
    bus(0, OFS_EPC, 0, r);
    chk(r, ZERO_WORD);
    bus(0, 8'h40, 0, r);
    chk(r, ZERO_WORD);
    chk(hresp, HRESP_OKAY);
    $display("bus test done");
    for (int i = 0; i < 20; i++) exc(ef[i], ec[i]);
    $display("exception test done");
    for (int i = 0; i < 4; i++) begin
      bus(1, OFS_TVEC, 32'h0000_4000 | i[0], r);
      bus(1, OFS_STATUS, 32'h0000_0008, r);
      fault(i[0], i[1]);
      wait_trap(32'h8000_0400 + i, i[0] ? 32'h0000_403C : 32'h0000_4000);
      bus(0, OFS_STATUS, 0, r);
      chk(r & 32'h88, 32'h0000_0080);
      chk(nmi_pending, 1'b0);
    end
    $display("nmi test done");
    debug_mode <= 1'b1;
    fault(1'b1, 1'b0);
    fault(1'b0, 1'b1);
    repeat (4) begin
      @(posedge hclk);
      #1;
      chk(trap_take, 1'b0);
    end
    chk(nmi_pending, 1'b1);
    bus(0, OFS_DBGCTL, 0, r);
    chk(r & 32'h8, 32'h0000_0008);
    debug_mode <= 1'b0;
    wait_trap(32'h8000_0401, 32'h0000_403C);
    single_step <= 1'b1;
    fault(1'b0, 1'b0);
    repeat (4) begin
      @(posedge hclk);
      #1;
      chk(trap_take, 1'b0);
    end
    single_step <= 1'b0;
    wait_trap(32'h8000_0400, 32'h0000_403C);
    $display("masking test done");
    test_done();
  end
endmodule
